// ### shared/ccref_pkg.sv
// shared constants and types for the comparator and reference control block
package ccref_pkg;
  // register indices on the plain register port (byte addresses, one per register)
  localparam logic [3:0] OFF_CMP_CTRL0 = 4'h0;
  localparam logic [3:0] OFF_CMP_CTRL1 = 4'h1;
  localparam logic [3:0] OFF_REF_CTRL = 4'h2;
  localparam logic [3:0] OFF_IRQ_CTRL = 4'h3;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  // reference control field positions
  localparam int REF_EN_BIT = 7;
  localparam int REF_RANGE_BIT = 5;
  localparam logic [7:0] REF_WMASK = 8'hA_F;
  // comparator control 0 fields
  localparam int MODE_LSB = 0;
  localparam logic [7:0] CTRL0_WMASK = 8'h0_7;
  // interrupt control register fields (own register)
  localparam int GIE_BIT = 2;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT = 1;
  localparam int CIE_BIT = 0;
  // status register fields
  localparam int ST_FLAG_BIT = 0;
  localparam int ST_ON_BIT = 1;
  localparam int ST_OUT_BIT = 2;
  localparam int ST_SLEEP_BIT = 3;
  // reset values
  localparam logic [7:0] RST_REG = 8'h0_0;
  // comparator modes
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [2:0] MODE_OFF = 3'h7;
  // core sequencing states
  typedef enum logic [1:0] {
    CCREF_RUN = 2'b00,
    CCREF_SLEEP = 2'b01,
    CCREF_WAKE = 2'b10,
    CCREF_VECTOR = 2'b11
  } ccref_state_t;
  // analog reference control carrier
  typedef struct packed {
    logic enable;
    logic low_range;
    logic [3:0] level;
  } ccref_ref_t;
endpackage

// ### rtl/ccref_top.sv
// comparator mode, sleep wake and voltage reference control
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module ccref_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // core handshakes
  input wire logic sleep_req,
  input wire logic next_instr_done,
  // analog comparator output pin
  input wire logic cmp_out_pin,
  // analog side controls
  output logic cmp_power,
  output ccref_pkg::ccref_ref_t ref_ctrl,
  output logic [9:0] ref_level_num,
  // core sequencing
  output logic core_halted,
  output logic wake_pulse,
  output logic isr_vector
);
  // ratio numerator over 96: low 4*code, high 24+3*code
  function automatic logic [9:0] level_of(input logic low, input logic [3:0] code);
    logic [9:0] c;
    c = {6'h0_0, code};
    // ratio formula low
    // code/24 scaled
    if (low) level_of = 10'(c * 10'd4);
    else level_of = 10'(10'd24 + c * 10'd3);
  endfunction

  logic [7:0] cmp_ctrl0;
  logic [7:0] cmp_ctrl1;
  logic [7:0] ref_reg;
  logic [7:0] irq_ctrl;
  logic cmp_flag;
  logic sync1;
  logic sync2;
  logic out_q;
  ccref_pkg::ccref_state_t state;
  ccref_pkg::ccref_state_t next_state;

  // address decode as named wires
  wire logic wr_c0 = reg_wr && reg_addr == ccref_pkg::OFF_CMP_CTRL0;
  wire logic wr_c1 = reg_wr && reg_addr == ccref_pkg::OFF_CMP_CTRL1;
  wire logic wr_ref = reg_wr && reg_addr == ccref_pkg::OFF_REF_CTRL;
  wire logic wr_irq = reg_wr && reg_addr == ccref_pkg::OFF_IRQ_CTRL;
  wire logic wr_st = reg_wr && reg_addr == ccref_pkg::OFF_STATUS;
  wire logic [2:0] mode = cmp_ctrl0[ccref_pkg::MODE_LSB +: 3];
  wire logic cmp_on = mode != ccref_pkg::MODE_RESET && mode != ccref_pkg::MODE_OFF;
  // output change only counts while the comparator runs; sleep does not gate it
  wire logic cmp_change = cmp_on && (sync2 != out_q);
  wire logic wake_ok = irq_ctrl[ccref_pkg::CIE_BIT] && irq_ctrl[ccref_pkg::PERIPHERAL_IRQ_ENABLE_BIT];
  wire logic global_irq_enable = irq_ctrl[ccref_pkg::GIE_BIT];
  wire logic [7:0] status = {4'h0, state == ccref_pkg::CCREF_SLEEP, sync2, cmp_on, cmp_flag};
  wire logic [7:0] rd_mux =
    reg_addr == ccref_pkg::OFF_CMP_CTRL0 ? cmp_ctrl0 :
    reg_addr == ccref_pkg::OFF_CMP_CTRL1 ? cmp_ctrl1 :
    reg_addr == ccref_pkg::OFF_REF_CTRL ? ref_reg :
    reg_addr == ccref_pkg::OFF_IRQ_CTRL ? irq_ctrl :
    reg_addr == ccref_pkg::OFF_STATUS ? status : 8'h0_0;

  // pin synchroniser, first stage read only by the second
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      out_q <= 1'b0;
    end else begin
      sync1 <= cmp_out_pin;
      sync2 <= sync1;
      out_q <= sync2;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cmp_ctrl0 <= ccref_pkg::RST_REG;
      cmp_ctrl1 <= ccref_pkg::RST_REG;
      irq_ctrl <= ccref_pkg::RST_REG;
    end else begin
      if (wr_c0) cmp_ctrl0 <= reg_wdata & ccref_pkg::CTRL0_WMASK;
      if (wr_c1) cmp_ctrl1 <= reg_wdata;
      if (wr_irq) irq_ctrl <= {5'h0_0, reg_wdata[2:0]};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) ref_reg <= ccref_pkg::RST_REG;
    else if (wr_ref) ref_reg <= reg_wdata & ccref_pkg::REF_WMASK;
  end

  // change flag: set wins over a write-one clear in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) cmp_flag <= 1'b0;
    else if (cmp_change) cmp_flag <= 1'b1;
    else if (wr_st && reg_wdata[ccref_pkg::ST_FLAG_BIT]) cmp_flag <= 1'b0;
  end

  // sleep / wake sequencing
  always_comb begin
    next_state = state;
    case (state)
      ccref_pkg::CCREF_RUN: begin
        if (sleep_req) next_state = ccref_pkg::CCREF_SLEEP;
      end
      ccref_pkg::CCREF_SLEEP: begin
        if (cmp_change && wake_ok) next_state = ccref_pkg::CCREF_WAKE;
      end
      ccref_pkg::CCREF_WAKE: begin
        // next instruction first; then vector if global enable
        if (next_instr_done) begin
          next_state = global_irq_enable ? ccref_pkg::CCREF_VECTOR : ccref_pkg::CCREF_RUN;
        end
      end
      ccref_pkg::CCREF_VECTOR: next_state = ccref_pkg::CCREF_RUN;
      default: next_state = ccref_pkg::CCREF_RUN;
    endcase
  end

  // registered outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= ccref_pkg::CCREF_RUN;
      reg_rdata <= 8'h0_0;
      cmp_power <= 1'b0;
      ref_ctrl <= '0;
      ref_level_num <= 10'h0_00;
      core_halted <= 1'b0;
      wake_pulse <= 1'b0;
      isr_vector <= 1'b0;
    end else begin
      state <= next_state;
      reg_rdata <= reg_rd ? rd_mux : 8'h0_0;
      cmp_power <= cmp_on;
      ref_ctrl.enable <= ref_reg[ccref_pkg::REF_EN_BIT];
      ref_ctrl.low_range <= ref_reg[ccref_pkg::REF_RANGE_BIT];
      ref_ctrl.level <= ref_reg[3:0];
      ref_level_num <= ref_reg[ccref_pkg::REF_EN_BIT]
        ? level_of(ref_reg[ccref_pkg::REF_RANGE_BIT], ref_reg[3:0]) : 10'h0_00;
      core_halted <= next_state == ccref_pkg::CCREF_SLEEP;
      wake_pulse <= state == ccref_pkg::CCREF_SLEEP && next_state == ccref_pkg::CCREF_WAKE;
      isr_vector <= next_state == ccref_pkg::CCREF_VECTOR;
    end
  end

  // assertions
  property p_off_codes;
    @(posedge mclk) disable iff (rst)
      (mode == ccref_pkg::MODE_OFF || mode == ccref_pkg::MODE_RESET) |=> !cmp_power;
  endproperty
  a_off_codes: assert property (p_off_codes) else $error("comparator on in off mode");

  property p_sleep_run;
    @(posedge mclk) disable iff (rst)
      (cmp_on && state == ccref_pkg::CCREF_SLEEP) |=> cmp_power;
  endproperty
  a_sleep_run: assert property (p_sleep_run) else $error("comparator dropped in sleep");

  property p_wake_gate;
    @(posedge mclk) disable iff (rst)
      (state == ccref_pkg::CCREF_SLEEP && !wake_ok) |=> state != ccref_pkg::CCREF_WAKE;
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake without enables");

  sequence s_wake;
    state == ccref_pkg::CCREF_SLEEP && cmp_change && wake_ok;
  endsequence
  property p_wake_seq;
    @(posedge mclk) disable iff (rst)
      s_wake |=> state == ccref_pkg::CCREF_WAKE && !isr_vector;
  endproperty
  a_wake_seq: assert property (p_wake_seq) else $error("vector before next instruction");

  property p_vector;
    @(posedge mclk) disable iff (rst)
      (state == ccref_pkg::CCREF_WAKE && next_instr_done && global_irq_enable) |=> isr_vector;
  endproperty
  a_vector: assert property (p_vector) else $error("no vector with global enable");

  property p_reset;
    @(posedge mclk) rst |=> cmp_ctrl0 == 8'h0_0 && cmp_ctrl1 == 8'h0_0;
  endproperty
  a_reset: assert property (p_reset) else $error("comparator registers not cleared");

  property p_unimpl;
    @(posedge mclk) disable iff (rst)
      reg_rd && reg_addr == ccref_pkg::OFF_REF_CTRL |=> reg_rdata[6] == 1'b0 && !reg_rdata[4];
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bits read set");

  property p_ground;
    @(posedge mclk) disable iff (rst)
      !ref_reg[ccref_pkg::REF_EN_BIT] |=> ref_level_num == 10'h0_00 && !ref_ctrl.enable;
  endproperty
  a_ground: assert property (p_ground) else $error("reference not grounded");

  property p_write_next;
    @(posedge mclk) disable iff (rst)
      wr_ref ##1 !wr_ref |=> ref_ctrl.level == $past(reg_wdata[3:0], 2)
        && ref_ctrl.low_range == $past(reg_wdata[5], 2);
  endproperty
  a_write_next: assert property (p_write_next) else $error("reference write late");

  property p_levels;
    @(posedge mclk) disable iff (rst)
      ref_reg[ccref_pkg::REF_EN_BIT] && !ref_reg[ccref_pkg::REF_RANGE_BIT] |=>
        ref_level_num == 10'(10'd24 + 10'(ref_ctrl.level) * 10'd3);
  endproperty
  a_levels: assert property (p_levels) else $error("high range level wrong");

  property p_flag_set;
    @(posedge mclk) disable iff (rst)
      cmp_change |=> cmp_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("change flag lost");

  property p_ref_range;
    @(posedge mclk) disable iff (rst)
      1'b1 |=> ref_ctrl.low_range == $past(ref_reg[ccref_pkg::REF_RANGE_BIT]);
  endproperty
  a_ref_range: assert property (p_ref_range) else $error("range select wrong");

  property p_ref_level;
    @(posedge mclk) disable iff (rst)
      1'b1 |=> ref_ctrl.level == $past(ref_reg[3:0]);
  endproperty
  a_ref_level: assert property (p_ref_level) else $error("level code wrong");

  // low range scale
  // four times the code equals code over 24 in 96ths of supply
  property p_low_levels;
    @(posedge mclk) disable iff (rst)
      ref_reg[ccref_pkg::REF_EN_BIT] && ref_reg[ccref_pkg::REF_RANGE_BIT] |=>
        ref_level_num == {4'h0, $past(ref_reg[3:0]), 2'b00};
  endproperty
  a_low_levels: assert property (p_low_levels) else $error("low range level wrong");

  property p_enable_indep;
    @(posedge mclk) disable iff (rst)
      1'b1 |=> ref_ctrl.enable == $past(ref_reg[ccref_pkg::REF_EN_BIT]);
  endproperty
  a_enable_indep: assert property (p_enable_indep) else $error("enable not followed");

  property p_ref_mask;
    @(posedge mclk) disable iff (rst)
      1'b1 |-> !ref_reg[6] && !ref_reg[4];
  endproperty
  a_ref_mask: assert property (p_ref_mask) else $error("unimplemented bit stored");

  property p_reset_off;
    @(posedge mclk) rst |=> !cmp_power && mode == ccref_pkg::MODE_RESET;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("comparator on after reset");

  property p_power_on;
    @(posedge mclk) disable iff (rst)
      cmp_on |=> cmp_power;
  endproperty
  a_power_on: assert property (p_power_on) else $error("comparator not powered");

  property p_ctrl0_mask;
    @(posedge mclk) disable iff (rst)
      1'b1 |-> cmp_ctrl0[7:3] == 5'h0_0;
  endproperty
  a_ctrl0_mask: assert property (p_ctrl0_mask) else $error("mode register upper bits set");

  property p_halted;
    @(posedge mclk) disable iff (rst)
      state == ccref_pkg::CCREF_SLEEP && !(cmp_change && wake_ok) |=> core_halted;
  endproperty
  a_halted: assert property (p_halted) else $error("core released without wake");

  property p_wake_once;
    @(posedge mclk) disable iff (rst)
      wake_pulse |=> !wake_pulse;
  endproperty
  a_wake_once: assert property (p_wake_once) else $error("wake pulse too long");

  property p_wait_instr;
    @(posedge mclk) disable iff (rst)
      state == ccref_pkg::CCREF_WAKE && !next_instr_done |=>
        state == ccref_pkg::CCREF_WAKE && !isr_vector;
  endproperty
  a_wait_instr: assert property (p_wait_instr) else $error("left wake too early");

  property p_no_gie;
    @(posedge mclk) disable iff (rst)
      state == ccref_pkg::CCREF_WAKE && next_instr_done && !global_irq_enable |=>
        !isr_vector && state == ccref_pkg::CCREF_RUN;
  endproperty
  a_no_gie: assert property (p_no_gie) else $error("vector without global enable");

  property p_vector_once;
    @(posedge mclk) disable iff (rst)
      isr_vector |=> !isr_vector;
  endproperty
  a_vector_once: assert property (p_vector_once) else $error("vector pulse too long");

  property p_write_ref;
    @(posedge mclk) disable iff (rst)
      wr_ref |=> ref_reg == ($past(reg_wdata) & ccref_pkg::REF_WMASK);
  endproperty
  a_write_ref: assert property (p_write_ref) else $error("reference register not written");
endmodule
`default_nettype wire

// ### verif/test_ccref_top.sv
// self-checking bench for the comparator and reference control block
`timescale 1ns/1ps
`default_nettype none
module test_ccref_top;
  // stimulus and observed outputs
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, sleep_req = 1'b0;
  logic next_instr_done = 1'b0, cmp_out_pin = 1'b0;
  logic [7:0] reg_rdata;
  logic cmp_power, core_halted, wake_pulse, isr_vector, seen;
  ccref_pkg::ccref_ref_t ref_ctrl;
  logic [9:0] ref_level_num;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;

  ccref_top uut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_req(sleep_req),
    .next_instr_done(next_instr_done), .cmp_out_pin(cmp_out_pin), .cmp_power(cmp_power),
    .ref_ctrl(ref_ctrl), .ref_level_num(ref_level_num), .core_halted(core_halted),
    .wake_pulse(wake_pulse), .isr_vector(isr_vector));

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  // hang guard: the whole run needs well under two thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("checks run %0d, failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // one-cycle write strobe, taken at the following edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample there
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] mask);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & mask, exp);
  endtask

  task automatic do_reset;
    @(posedge mclk);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
  endtask

  // enter sleep, toggle the comparator output, watch wake and vector
  task automatic sleep_case(input logic [2:0] irq, input logic exp_wake, input logic exp_isr);
    wr(ccref_pkg::OFF_IRQ_CTRL, {5'h00, irq});
    wr(ccref_pkg::OFF_CMP_CTRL0, 8'h01);
    wr(ccref_pkg::OFF_STATUS, 8'h01);
    @(posedge mclk);
    sleep_req <= 1'b1;
    @(posedge mclk);
    sleep_req <= 1'b0;
    cyc(2);
    rdchk(ccref_pkg::OFF_STATUS, 8'h0a, 8'h0a);
    chk(cmp_power, 1'b1);
    @(posedge mclk);
    cmp_out_pin <= ~cmp_out_pin;
    seen = 1'b0;
    repeat (20) begin
      @(posedge mclk);
      #1;
      if (wake_pulse === 1'b1) seen = 1'b1;
    end
    chk(seen, exp_wake);
    rdchk(ccref_pkg::OFF_STATUS, 8'h01, 8'h01);
    chk(core_halted, !exp_wake);
    if (exp_wake) begin
      @(posedge mclk);
      next_instr_done <= 1'b1;
      seen = 1'b0;
      repeat (5) begin
        @(posedge mclk);
        next_instr_done <= 1'b0;
        #1;
        if (isr_vector === 1'b1) seen = 1'b1;
      end
      chk(seen, exp_isr);
    end
  endtask

  // main sequence
  initial begin
    cyc(2);
    rst <= 1'b0;
    for (int a = 0; a < 5; a++) rdchk(a[3:0], 8'h00, 8'hff);
    wr(4'h5, 8'hff);
    rdchk(4'h5, 8'h00, 8'hff);
    wr(ccref_pkg::OFF_CMP_CTRL1, 8'h5a);
    rdchk(ccref_pkg::OFF_CMP_CTRL1, 8'h5a, 8'hff);
    wr(ccref_pkg::OFF_IRQ_CTRL, 8'hff);
    rdchk(ccref_pkg::OFF_IRQ_CTRL, 8'h07, 8'hff);
    wr(ccref_pkg::OFF_CMP_CTRL0, 8'hff);
    rdchk(ccref_pkg::OFF_CMP_CTRL0, 8'h07, 8'hff);
    // every mode code; only 000 and 111 leave the comparator unpowered
    for (int m = 0; m < 8; m++) begin
      wr(ccref_pkg::OFF_CMP_CTRL0, m[7:0]);
      cyc(3);
      #1;
      chk(cmp_power, (m != 0 && m != 7));
    end
    wr(ccref_pkg::OFF_REF_CTRL, 8'hff);
    rdchk(ccref_pkg::OFF_REF_CTRL, 8'haf, 8'hff);
    wr(ccref_pkg::OFF_CMP_CTRL0, 8'h00);
    cyc(3);
    #1;
    chk(ref_ctrl.enable, 1'b1);
    // both ranges, all sixteen codes, level in 96ths of supply
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 16; c++) begin
        wr(ccref_pkg::OFF_REF_CTRL, {2'b10, r[0], 1'b0, c[3:0]});
        cyc(2);
        #1;
        chk(ref_ctrl, {1'b1, r[0], c[3:0]});
        chk(ref_level_num, 16'((r == 1) ? 4 * c : 24 + 3 * c));
      end
    end
    wr(ccref_pkg::OFF_REF_CTRL, 8'h2f);
    cyc(2);
    #1;
    chk(ref_level_num, 16'h0000);
    wr(ccref_pkg::OFF_REF_CTRL, 8'h20);
    cyc(2);
    #1;
    chk({ref_ctrl, ref_level_num}, 16'h4000);
    sleep_case(3'b101, 1'b0, 1'b0);
    do_reset();
    #1;
    chk(core_halted, 1'b0);
    for (int a = 0; a < 4; a++) rdchk(a[3:0], 8'h00, 8'hff);
    sleep_case(3'b011, 1'b1, 1'b0);
    sleep_case(3'b111, 1'b1, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
